// *** verilog/cise_pkg.sv ***
// constants and types for the instruction subset execution block
package cise_pkg;
   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [7:0] A_CTRL  = 8'h00; // bit0: extended set enable
   localparam logic [7:0] A_BANK  = 8'h04; // bank select pointer
   localparam logic [7:0] A_ACC   = 8'h08; // working register
   localparam logic [7:0] A_FLAGS = 8'h0C; // status flags
   localparam logic [7:0] A_PC    = 8'h10; // program counter
   localparam logic [7:0] A_INSTR = 8'h14; // write starts one instruction
   localparam logic [7:0] A_STATE = 8'h18; // busy, phase, stack depth
   localparam logic [7:0] A_FADDR = 8'h1C; // file byte pointer
   localparam logic [7:0] A_FDATA = 8'h20; // file byte window
   localparam logic [7:0] A_IBASE = 8'h24; // indexed literal offset base
   localparam logic [7:0] A_TOS   = 8'h28; // top of return stack
   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int F_C = 0;
   localparam int F_DC = 1;
   localparam int F_Z = 2;
   localparam int F_OV = 3;
   localparam int F_N = 4;
   localparam int S_BUSY = 0;
   localparam int S_Q_LSB = 2;
   localparam int S_SP_LSB = 8;
   localparam int I_ACC = 8;  // access bit of a byte instruction
   localparam int I_DST = 9;  // destination bit
   // ----------------------------------------------------------------
   // encodings, phases, reset values
   // ----------------------------------------------------------------
   localparam logic [7:0]  OP_ADD_LITERAL_TO_ACCUMULATOR = 8'h0F;
   localparam logic [5:0]  OP_ADD_ACCUMULATOR_TO_FILE = 6'h09;
   localparam logic [5:0]  OP_AND_ACCUMULATOR_WITH_FILE = 6'h05;
   localparam logic [7:0]  OP_BC    = 8'hE2;
   localparam logic [4:0]  OP_RELATIVE_SUBROUTINE_CALL = 5'h1B;
   localparam logic [15:0] OP_SWRST = 16'h00FF;
   localparam logic [7:0]  IDX_LIMIT = 8'h5F;
   localparam logic [7:0]  ACC_SPLIT = 8'h60;
   localparam logic [1:0]  Q_DEC = 2'h0;
   localparam logic [1:0]  Q_RD  = 2'h1;
   localparam logic [1:0]  Q_PR  = 2'h2;
   localparam logic [1:0]  Q_WR  = 2'h3;
   localparam logic [2:0]  SZ_WORD = 3'h2;
   localparam logic [7:0]  RST_BYTE = 8'h00;
   localparam logic [4:0]  RST_FLAGS = 5'h00;
   typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_NOP} cise_st_t;
   typedef enum logic [2:0] {CL_ADD_LITERAL_TO_ACCUMULATOR, CL_ADD_ACCUMULATOR_TO_FILE, CL_AND_ACCUMULATOR_WITH_FILE, CL_BC,
                             CL_RELATIVE_SUBROUTINE_CALL, CL_SWRST, CL_OTHER} cise_cls_t;
endpackage : cise_pkg

// *** verilog/cise_core.sv ***
// instruction subset decode and execute core with an AHB-Lite slave
// Function
// RULE1: add literal to accumulator, write accumulator, update N OV C DC Z.
// RULE2: add accumulator to file byte; destination bit picks accumulator or file.
// RULE3: access bit 0 uses access bank, 1 uses bank select pointer.
// RULE4: access 0, extended set on, address up to 5Fh: indexed offset.
// RULE5: and accumulator with file byte, route by destination, update N Z only.
// RULE6: branch on carry loads PC+2+2n only when carry set; no flags.
// RULE7: branch on carry takes one cycle, two when taken with a no-op.
// RULE8: relative call pushes PC+2, then loads PC+2+2n; two cycles.
// RULE9: software reset opcode resets all master-clear registers; one cycle.
// RULE10: each cycle has decode, read, process, write phases; one word each.
//
// The register addresses and the AHB-Lite register port were decided locally.
module cise_core
   import cise_pkg::*;
#(
   parameter int PC_W      = 21,
   parameter int STK_DEPTH = 31,
   parameter int BANK_W    = 4
)(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata
);
   localparam int DA_W = BANK_W + 8;
   localparam int SP_W = $clog2(STK_DEPTH + 1);

   // ----------------------------------------------------------------
   // decoding helpers
   // ----------------------------------------------------------------
   function automatic cise_cls_t cls_of(input logic [15:0] ir);
      if (ir[15:8] == OP_ADD_LITERAL_TO_ACCUMULATOR) cls_of = CL_ADD_LITERAL_TO_ACCUMULATOR;
      else if (ir[15:10] == OP_ADD_ACCUMULATOR_TO_FILE) cls_of = CL_ADD_ACCUMULATOR_TO_FILE;
      else if (ir[15:10] == OP_AND_ACCUMULATOR_WITH_FILE) cls_of = CL_AND_ACCUMULATOR_WITH_FILE;
      else if (ir[15:8] == OP_BC) cls_of = CL_BC;
      else if (ir[15:11] == OP_RELATIVE_SUBROUTINE_CALL) cls_of = CL_RELATIVE_SUBROUTINE_CALL;
      else if (ir == OP_SWRST) cls_of = CL_SWRST;
      else cls_of = CL_OTHER;
   endfunction : cls_of

   function automatic logic [DA_W-1:0] eff_addr(
      input logic [15:0] ir, input logic [BANK_W-1:0] bk,
      input logic [DA_W-1:0] ib, input logic ext);
      logic [7:0] f;
      f = ir[7:0];
      if (ir[I_ACC]) eff_addr = {bk, f};                 // [RULE3]
      else if (ext && f <= IDX_LIMIT) eff_addr = DA_W'(ib + f); // [RULE4]
      else if (f < ACC_SPLIT) eff_addr = {{BANK_W{1'b0}}, f}; // [RULE3]
      else eff_addr = {{BANK_W{1'b1}}, f};
   endfunction : eff_addr

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   cise_st_t          st_reg;
   cise_cls_t         cls_reg;
   logic [1:0]        q_reg;
   logic [15:0]       ir_reg;
   logic [7:0]        opnd_reg, res_reg, acc_reg;
   logic [4:0]        rflg_reg, flg_reg;
   logic [PC_W-1:0]   pc_reg;
   logic [BANK_W-1:0] bank_reg;
   logic              ext_reg;
   logic [DA_W-1:0]   ibase_reg, faddr_reg;
   logic [SP_W-1:0]   sp_reg;
   logic [PC_W-1:0]   stk [STK_DEPTH];
   logic [7:0]        dmem [2**DA_W];
   logic              wr_pend_reg, hready_reg;
   logic [7:0]        wa_reg;
   logic [31:0]       hrdata_reg, rd_val;

   logic              addr_ok, bus_wr, run, q4, swrst, byte_op, c_take;
   logic              dest_f;
   logic [DA_W-1:0]   ea;
   logic [PC_W-1:0]   pc_inc, br_off, rc_off, tos_val;
   logic [8:0]        sum9;
   logic [4:0]        hsum5;

   assign addr_ok = hsel && htrans[1] && hready && hsize == SZ_WORD;
   // bus writes to core state apply only when idle, so they never race the core; writes during execution are dropped
   assign bus_wr  = wr_pend_reg && st_reg == ST_IDLE;
   assign run     = st_reg == ST_EXEC;
   assign q4      = run && q_reg == Q_WR;
   assign swrst   = q4 && cls_reg == CL_SWRST;               // [RULE9]
   assign byte_op = cls_reg == CL_ADD_ACCUMULATOR_TO_FILE || cls_reg == CL_AND_ACCUMULATOR_WITH_FILE;
   assign dest_f  = ir_reg[I_DST];
   assign c_take  = cls_reg == CL_BC && flg_reg[F_C];        // [RULE6]
   assign ea      = eff_addr(ir_reg, bank_reg, ibase_reg, ext_reg);
   assign pc_inc  = pc_reg + PC_W'(2);
   assign br_off  = {{(PC_W-9){ir_reg[7]}}, ir_reg[7:0], 1'b0};
   assign rc_off  = {{(PC_W-12){ir_reg[10]}}, ir_reg[10:0], 1'b0};
   assign tos_val = (sp_reg == '0) ? '0 : stk[sp_reg - SP_W'(1)];
   assign sum9    = {1'b0, acc_reg} + {1'b0, opnd_reg};
   assign hsum5   = {1'b0, acc_reg[3:0]} + {1'b0, opnd_reg[3:0]};

   // ----------------------------------------------------------------
   // phase sequencer: four clocks per instruction cycle
   // ----------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_reg <= ST_IDLE;
         q_reg  <= Q_DEC;
      end else if (swrst) begin
         st_reg <= ST_IDLE;
         q_reg  <= Q_DEC;
      end else begin
         unique case (st_reg)
            ST_IDLE: begin
               q_reg <= Q_DEC;
               if (bus_wr && wa_reg == A_INSTR) st_reg <= ST_EXEC;
            end
            ST_EXEC: begin
               q_reg <= q_reg + 2'h1;                        // [RULE10]
               if (q_reg == Q_WR)                            // [RULE7]
                  st_reg <= (c_take || cls_reg == CL_RELATIVE_SUBROUTINE_CALL) ? ST_NOP
                                                            : ST_IDLE;
            end
            ST_NOP: begin
               q_reg <= q_reg + 2'h1;
               if (q_reg == Q_WR) st_reg <= ST_IDLE;         // [RULE8]
            end
            default: st_reg <= ST_IDLE;
         endcase
      end
   end

   // instruction word and its decode, held for the whole cycle
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ir_reg  <= 16'h0000;
         cls_reg <= CL_OTHER;
      end else begin
         if (st_reg == ST_IDLE && bus_wr && wa_reg == A_INSTR)
            ir_reg <= hwdata[15:0];
         if (run && q_reg == Q_DEC) cls_reg <= cls_of(ir_reg); // [RULE10]
      end
   end

   // operand read and data processing phases
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         opnd_reg <= RST_BYTE;
         res_reg  <= RST_BYTE;
         rflg_reg <= RST_FLAGS;
      end else if (run && q_reg == Q_RD) begin
         opnd_reg <= (cls_reg == CL_ADD_LITERAL_TO_ACCUMULATOR) ? ir_reg[7:0] : dmem[ea];
      end else if (run && q_reg == Q_PR) begin
         rflg_reg <= flg_reg;
         if (cls_reg == CL_AND_ACCUMULATOR_WITH_FILE) begin
            res_reg           <= acc_reg & opnd_reg;          // [RULE5]
            rflg_reg[F_N]     <= acc_reg[7] & opnd_reg[7];
            rflg_reg[F_Z]     <= (acc_reg & opnd_reg) == 8'h00;
         end else begin
            res_reg           <= sum9[7:0];             // [RULE1] [RULE2]
            rflg_reg[F_N]     <= sum9[7];
            rflg_reg[F_Z]     <= sum9[7:0] == 8'h00;
            rflg_reg[F_C]     <= sum9[8];
            rflg_reg[F_DC]    <= hsum5[4];
            rflg_reg[F_OV]    <= (acc_reg[7] == opnd_reg[7]) &&
                                 (sum9[7] != acc_reg[7]);
         end
      end
   end

   // working register and flags, written in the last phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         acc_reg <= RST_BYTE;
         flg_reg <= RST_FLAGS;
      end else if (swrst) begin                              // [RULE9]
         acc_reg <= RST_BYTE;
         flg_reg <= RST_FLAGS;
      end else if (q4) begin
         if (cls_reg == CL_ADD_LITERAL_TO_ACCUMULATOR || (byte_op && !dest_f))
            acc_reg <= res_reg;                       // [RULE1] [RULE2]
         if (cls_reg == CL_ADD_LITERAL_TO_ACCUMULATOR || byte_op)
            flg_reg <= rflg_reg;                             // [RULE5]
      end else if (bus_wr) begin
         if (wa_reg == A_ACC) acc_reg <= hwdata[7:0];
         if (wa_reg == A_FLAGS) flg_reg <= hwdata[4:0];
      end
   end

   // file memory: core write-back first, software window otherwise
   always_ff @(posedge hclk) begin
      if (q4 && byte_op && dest_f) dmem[ea] <= res_reg;       // [RULE2]
      else if (bus_wr && wa_reg == A_FDATA) dmem[faddr_reg] <= hwdata[7:0];
   end

   // program counter; a taken branch or call needs a refetch no-op
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) pc_reg <= '0;
      else if (swrst) pc_reg <= '0;                          // [RULE9]
      else if (q4) begin
         if (c_take) pc_reg <= pc_inc + br_off;              // [RULE6]
         else if (cls_reg == CL_RELATIVE_SUBROUTINE_CALL) pc_reg <= pc_inc + rc_off; // [RULE8]
         else pc_reg <= pc_inc;
      end else if (bus_wr && wa_reg == A_PC) pc_reg <= hwdata[PC_W-1:0];
   end

   // return stack: push in the read phase, saturates when full
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) sp_reg <= '0;
      else if (swrst) sp_reg <= '0;
      else if (run && q_reg == Q_RD && cls_reg == CL_RELATIVE_SUBROUTINE_CALL &&
               sp_reg < SP_W'(STK_DEPTH)) begin
         stk[sp_reg] <= pc_inc;                              // [RULE8]
         sp_reg      <= sp_reg + SP_W'(1);
      end
   end

   // software-set configuration; the opcode reset stays a synchronous branch
   // so the asynchronous branch only ever loads constants
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bank_reg  <= '0;
         ext_reg   <= 1'b0;
         ibase_reg <= '0;
         faddr_reg <= '0;
      end else if (swrst) begin                              // [RULE9]
         bank_reg  <= '0;
         ext_reg   <= 1'b0;
         ibase_reg <= '0;
         faddr_reg <= '0;
      end else if (bus_wr) begin
         if (wa_reg == A_BANK) bank_reg <= hwdata[BANK_W-1:0];
         if (wa_reg == A_CTRL) ext_reg <= hwdata[0];
         if (wa_reg == A_IBASE) ibase_reg <= hwdata[DA_W-1:0];
         if (wa_reg == A_FADDR) faddr_reg <= hwdata[DA_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // AHB-Lite slave, zero wait states, always OKAY
   // ----------------------------------------------------------------
   always_comb begin
      rd_val = 32'h0000_0000;
      unique case (haddr[7:0])
         A_CTRL:  rd_val[0] = ext_reg;
         A_BANK:  rd_val[BANK_W-1:0] = bank_reg;
         A_ACC:   rd_val[7:0] = acc_reg;
         A_FLAGS: rd_val[4:0] = flg_reg;
         A_PC:    rd_val[PC_W-1:0] = pc_reg;
         A_INSTR: rd_val[15:0] = ir_reg;
         A_STATE: begin
            rd_val[S_BUSY] = st_reg != ST_IDLE;
            rd_val[S_Q_LSB+:2] = q_reg;
            rd_val[S_SP_LSB+:SP_W] = sp_reg;
         end
         A_FADDR: rd_val[DA_W-1:0] = faddr_reg;
         A_FDATA: rd_val[7:0] = dmem[faddr_reg];
         A_IBASE: rd_val[DA_W-1:0] = ibase_reg;
         A_TOS:   rd_val[PC_W-1:0] = tos_val;
         default: rd_val = 32'h0000_0000;   // unmapped reads as zero
      endcase
   end

   // read data is captured in the address phase for a registered output
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wa_reg      <= 8'h00;
         hrdata_reg  <= 32'h0000_0000;
         hready_reg  <= 1'b1;
      end else begin
         hready_reg  <= 1'b1;
         wr_pend_reg <= addr_ok && hwrite;
         if (addr_ok) wa_reg <= haddr[7:0];
         if (addr_ok && !hwrite) hrdata_reg <= rd_val;
      end
   end

   assign hreadyout = hready_reg;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_reg;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   logic [7:0] bank_byte, idx_byte;
   assign bank_byte = dmem[{bank_reg, ir_reg[7:0]}];
   assign idx_byte  = dmem[DA_W'(ibase_reg + ir_reg[7:0])];

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   AST_ADD_LITERAL_TO_ACCUMULATOR_SUM: assert property (run && q_reg == Q_RD && // [RULE1]
      cls_reg == CL_ADD_LITERAL_TO_ACCUMULATOR |-> ##3 acc_reg ==
      8'($past(acc_reg, 3) + $past(ir_reg, 3)))
      else $error("literal add gave a wrong sum");
   AST_ADD_ACCUMULATOR_TO_FILE_FILE: assert property (q4 && cls_reg == CL_ADD_ACCUMULATOR_TO_FILE && // [RULE2]
      dest_f |=> acc_reg == $past(acc_reg) && dmem[$past(ea)] ==
      $past(res_reg)) else $error("file add routed wrongly");
   AST_BANKED: assert property (run && q_reg == Q_RD && byte_op && // [RULE3]
      ir_reg[I_ACC] |=> opnd_reg == $past(bank_byte))
      else $error("banked operand wrong");
   AST_INDEXED: assert property (run && q_reg == Q_RD && byte_op && // [RULE4]
      !ir_reg[I_ACC] && ext_reg && ir_reg[7:0] <= IDX_LIMIT
      |=> opnd_reg == $past(idx_byte)) else $error("indexed operand wrong");
   AST_AND_FLAGS: assert property (q4 && cls_reg == CL_AND_ACCUMULATOR_WITH_FILE |=> // [RULE5]
      $stable(flg_reg[F_C]) && $stable(flg_reg[F_DC]) &&
      $stable(flg_reg[F_OV]) && flg_reg[F_Z] == ($past(res_reg) == 8'h00))
      else $error("and changed wrong flags");
   AST_BC_NOT: assert property (q4 && cls_reg == CL_BC && // [RULE6]
      !flg_reg[F_C] |=> pc_reg == $past(pc_inc) && st_reg == ST_IDLE)
      else $error("untaken branch misbehaved");
   AST_BC_TAKEN: assert property (q4 && c_take |=> // [RULE7]
      pc_reg == PC_W'($past(pc_inc) + $past(br_off)) ##0
      (st_reg == ST_NOP)[*4] ##1 st_reg == ST_IDLE)
      else $error("taken branch timing wrong");
   AST_RELATIVE_SUBROUTINE_CALL: assert property (run && q_reg == Q_RD && // [RULE8]
      cls_reg == CL_RELATIVE_SUBROUTINE_CALL && sp_reg < SP_W'(STK_DEPTH) |=>
      tos_val == $past(pc_inc) ##2
      pc_reg == PC_W'($past(pc_inc, 3) + $past(rc_off, 3)))
      else $error("relative call wrong");
   AST_SWRST: assert property (swrst |=> acc_reg == RST_BYTE && // [RULE9]
      pc_reg == '0 && flg_reg == RST_FLAGS && st_reg == ST_IDLE)
      else $error("software reset incomplete");
   AST_PHASES: assert property ($rose(run) |-> run[*4] ##1 !run) // [RULE10]
      else $error("instruction cycle not four phases");

   COV_BC_TAKEN: cover property (q4 && c_take);
   COV_RELATIVE_SUBROUTINE_CALL: cover property (q4 && cls_reg == CL_RELATIVE_SUBROUTINE_CALL);
   COV_SWRST: cover property (swrst);
   COV_INDEXED: cover property (run && q_reg == Q_RD && byte_op &&
      !ir_reg[I_ACC] && ext_reg && ir_reg[7:0] <= IDX_LIMIT);
endmodule : cise_core

// *** test/cise_host.sv ***
// bus master model issuing single word transfers to the block
module cise_host
   import cise_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hready,
   input  wire logic [31:0] hrdata,
   output logic             hsel,
   output logic [31:0]      haddr,
   output logic [1:0]       htrans,
   output logic             hwrite,
   output logic [2:0]       hsize,
   output logic [31:0]      hwdata,
   output logic             tout
);
   timeunit 1ns;
   timeprecision 1ns;

   // --------------------------------------------------------------
   // idle bus at time zero
   // --------------------------------------------------------------
   initial begin
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize  = SZ_WORD;
      hwdata = 32'h0;
      tout   = 1'b0;
   end

   // wait for hready at an edge; a stuck slave raises tout
   task automatic wait_rdy();
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 64);
      if (hready !== 1'b1) tout <= 1'b1;
   endtask : wait_rdy

   // address phase held until accepted, then the data phase
   task automatic xfer(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
      hsel   <= 1'b0;
      hwdata <= ~d; // released data lines do not keep the last value
   endtask : xfer
endmodule : cise_host

// *** test/tb.sv ***
// self-checking bench for the instruction subset execution block
module tb
   import cise_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic        hclk;
   logic        hresetn;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hready;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic        tout;
   int          error_cnt;
   int          checked;

   assign hready = hreadyout; // single slave drives the bus ready

   cise_core cise_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata));
   cise_host cise_host_i (.hclk(hclk), .hready(hready), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .tout(tout));

   // --------------------------------------------------------------
   // clock, checking and closing
   // --------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic wrap_up();
      $display("checks=%0d mismatches=%0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : wrap_up

   // a hung bus transfer ends the run as a failure
   always @(posedge hclk) begin
      if (tout === 1'b1) begin
         error_cnt++;
         wrap_up();
      end
   end

   // --------------------------------------------------------------
   // bus and execution helpers
   // --------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      cise_host_i.xfer(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      cise_host_i.xfer(1'b0, a, 32'h0, q);
   endtask : rd

   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] q;
      rd(a, q);
      chk(q, exp);
   endtask : rchk

   task automatic plant(input logic [11:0] a, input logic [7:0] v);
      wr(A_FADDR, {20'h0, a});
      wr(A_FDATA, {24'h0, v});
   endtask : plant

   // bounded poll until the core reports idle
   task automatic idle_wait();
      logic [31:0] q;
      int          n;
      n = 0;
      do begin
         rd(A_STATE, q);
         n++;
      end while (q[S_BUSY] !== 1'b0 && n < 40);
      if (q[S_BUSY] !== 1'b0) begin
         error_cnt++;
         wrap_up();
      end
   endtask : idle_wait

   // busy is probed six edges after issue: short ops are done by then
   task automatic exec(input logic [15:0] ins, input logic lng);
      logic [31:0] q;
      wr(A_INSTR, {16'h0, ins});
      repeat (4) @(posedge hclk);
      rd(A_STATE, q);
      chk({31'h0, q[S_BUSY]}, {31'h0, lng});
      idle_wait();
   endtask : exec

   // reference adder: result in [7:0], flags above
   function automatic logic [12:0] addf(input logic [7:0] a,
                                        input logic [7:0] b);
      logic [8:0] s;
      logic [4:0] f;
      s = {1'b0, a} + {1'b0, b};
      f[F_C] = s[8];
      f[F_DC] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
      f[F_Z] = (s[7:0] == 8'h00);
      f[F_OV] = (a[7] == b[7]) && (s[7] != a[7]);
      f[F_N] = s[7];
      return {f, s[7:0]};
   endfunction : addf

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_zero();
      logic [7:0] ra [10] = '{A_CTRL, A_BANK, A_ACC, A_FLAGS, A_PC,
                              A_IBASE, A_FADDR, A_STATE, A_TOS, 8'h40};
      wr(A_STATE, 32'h0000_1F0D); // read-only, must be ignored
      foreach (ra[i]) rchk(ra[i], 32'h0);
      chk({31'h0, hresp}, 32'h0);
      chk({31'h0, hreadyout}, 32'h1);
      $display("zero state test done");
   endtask : t_zero

   task automatic t_add_literal_to_accumulator();
      logic [15:0] tb_v [4] = '{16'h1015, 16'hFF01, 16'h7F01, 16'h8080};
      logic [12:0] r;
      foreach (tb_v[i]) begin
         wr(A_ACC, {24'h0, tb_v[i][15:8]});
         wr(A_FLAGS, 32'h0);
         wr(A_PC, 32'h20);
         wr(A_INSTR, {16'h0, OP_ADD_LITERAL_TO_ACCUMULATOR, tb_v[i][7:0]});
         wr(A_ACC, 32'h55); // lands mid-cycle, so it is dropped
         idle_wait();
         r = addf(tb_v[i][15:8], tb_v[i][7:0]);
         rchk(A_ACC, {24'h0, r[7:0]});
         rchk(A_FLAGS, {27'h0, r[12:8]});
         rchk(A_PC, 32'h22);
      end
      $display("add literal test done");
   endtask : t_add_literal_to_accumulator

   task automatic t_add_accumulator_to_file();
      logic [12:0] r;
      r = addf(8'hD9, 8'hC2);
      wr(A_BANK, 32'h2);
      plant(12'h2C2, 8'hC2);
      wr(A_ACC, 32'h17);
      exec({OP_ADD_ACCUMULATOR_TO_FILE, 1'b0, 1'b1, 8'hC2}, 1'b0);
      rchk(A_ACC, 32'hD9);
      rchk(A_FDATA, 32'hC2);
      exec({OP_ADD_ACCUMULATOR_TO_FILE, 1'b1, 1'b1, 8'hC2}, 1'b0);
      rchk(A_FDATA, 32'h9B);
      rchk(A_ACC, 32'hD9);
      rchk(A_FLAGS, {27'h0, r[12:8]});
      $display("add to file test done");
   endtask : t_add_accumulator_to_file

   // access bank, indexed window and its boundary at 5F/60
   task automatic t_addr();
      logic [20:0] tv [5] = '{{1'b0, 8'h10, 12'h010},
         {1'b0, 8'h80, 12'hF80}, {1'b1, 8'h10, 12'h310},
         {1'b1, 8'h5F, 12'h35F}, {1'b1, 8'h60, 12'hF60}};
      wr(A_BANK, 32'h5);
      wr(A_IBASE, 32'h300);
      foreach (tv[i]) begin
         wr(A_CTRL, {31'h0, tv[i][20]});
         plant(tv[i][11:0], 8'h20 + 8'(i));
         wr(A_ACC, 32'h1);
         exec({OP_ADD_ACCUMULATOR_TO_FILE, 1'b0, 1'b0, tv[i][19:12]}, 1'b0);
         rchk(A_ACC, 32'h21 + i);
      end
      wr(A_CTRL, 32'h0);
      $display("addressing test done");
   endtask : t_addr

   task automatic t_and_accumulator_with_file();
      logic [36:0] tv [3] = '{{8'h17, 8'hC2, 1'b0, 8'h02, 4'h0, 8'h0B},
         {8'h0D, 8'hC2, 1'b1, 8'h00, 4'h0, 8'h0F},
         {8'h80, 8'h81, 1'b0, 8'h80, 4'h0, 8'h1B}};
      wr(A_BANK, 32'h1);
      foreach (tv[i]) begin
         plant(12'h1C2, tv[i][28:21]);
         wr(A_FLAGS, 32'h0B);
         wr(A_ACC, {24'h0, tv[i][36:29]});
         exec({OP_AND_ACCUMULATOR_WITH_FILE, tv[i][20], 1'b1, 8'hC2}, 1'b0);
         rchk(A_ACC,
              {24'h0, tv[i][20] ? tv[i][36:29] : tv[i][19:12]});
         rchk(A_FDATA,
              {24'h0, tv[i][20] ? tv[i][19:12] : tv[i][28:21]});
         rchk(A_FLAGS, {24'h0, tv[i][7:0]});
      end
      $display("and with file test done");
   endtask : t_and_accumulator_with_file

   task automatic t_bc();
      logic [24:0] tv [3] = '{{1'b0, 8'h05, 12'h102, 4'h0},
         {1'b1, 8'h80, 12'h002, 4'h1}, {1'b1, 8'h7F, 12'h200, 4'h1}};
      foreach (tv[i]) begin
         wr(A_FLAGS, {31'h0, tv[i][24]});
         wr(A_PC, 32'h100);
         exec({OP_BC, tv[i][23:16]}, tv[i][0]);
         rchk(A_PC, {20'h0, tv[i][15:4]});
         rchk(A_FLAGS, {31'h0, tv[i][24]});
      end
      $display("branch on carry test done");
   endtask : t_bc

   task automatic t_relative_subroutine_call();
      logic [31:0] q;
      wr(A_PC, 32'h1000);
      exec({OP_RELATIVE_SUBROUTINE_CALL, 11'h400}, 1'b1);
      rchk(A_PC, 32'h802);
      rchk(A_TOS, 32'h1002);
      exec({OP_RELATIVE_SUBROUTINE_CALL, 11'h3FF}, 1'b1);
      rchk(A_PC, 32'h1002);
      rchk(A_TOS, 32'h804);
      rd(A_STATE, q);
      chk({27'h0, q[S_SP_LSB+:5]}, 32'h2);
      $display("relative call test done");
   endtask : t_relative_subroutine_call

   task automatic t_swrst();
      wr(A_CTRL, 32'h1);
      wr(A_BANK, 32'h3);
      wr(A_ACC, 32'h5A);
      wr(A_FLAGS, 32'h1F);
      wr(A_IBASE, 32'h123);
      wr(A_FADDR, 32'h456);
      wr(A_PC, 32'h80);
      exec(OP_SWRST, 1'b0);
      t_zero();
      $display("software reset test done");
   endtask : t_swrst

   // --------------------------------------------------------------
   // main sequence
   // --------------------------------------------------------------
   initial begin
      hresetn   = 1'b0;
      error_cnt = 0;
      checked   = 0;
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      t_zero();
      t_add_literal_to_accumulator();
      t_add_accumulator_to_file();
      t_addr();
      t_and_accumulator_with_file();
      t_bc();
      t_relative_subroutine_call();
      t_swrst();
      wrap_up();
   end
endmodule : tb
